/* File: rtl/ehc_pkg.sv */
// package of the host command and status register group
// shared by the register block and its bench; no timescale here
package ehc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] HOST_COMMAND_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] HOST_STATUS_OFS = 8'h24;
  localparam logic [ADDR_W-1:0] HOST_INTR_EN_OFS = 8'h28;

  // ----------------------------------------------------------------
  // command register fields
  // ----------------------------------------------------------------
  localparam int RUN_STOP_BIT = 0;
  localparam int HOST_RESET_BIT = 1;
  localparam int FRAME_LIST_LENGTH_LSB = 2;
  localparam int FRAME_LIST_LENGTH_W = 2;
  localparam int LIGHT_RESET_BIT = 7;
  localparam logic [31:0] HOST_COMMAND_RESET = 32'h00080b00;
  localparam logic [31:0] HOST_COMMAND_FIELDS = 32'h0000008f;

  // frame list length codes
  localparam logic [1:0] FLL_1024 = 2'h0;
  localparam logic [1:0] FLL_512 = 2'h1;
  localparam logic [1:0] FLL_256 = 2'h2;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int PORT_CHANGE_FLAG_BIT = 2;
  localparam int FRAME_LIST_WRAP_BIT = 3;
  localparam logic [31:0] HOST_STATUS_FLAGS = 32'h0000000c;
  localparam logic [31:0] HOST_STATUS_RESET = 32'h00000000;
  localparam logic [31:0] HOST_INTR_EN_RESET = 32'h00000000;

  // ----------------------------------------------------------------
  // frame index
  // ----------------------------------------------------------------
  localparam int FRAME_IDX_W = 13;
  localparam logic [FRAME_IDX_W-1:0] IDX_MAX_1024 = 13'h1fff;
  localparam logic [FRAME_IDX_W-1:0] IDX_MAX_512 = 13'h0fff;
  localparam logic [FRAME_IDX_W-1:0] IDX_MAX_256 = 13'h07ff;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MICROFRAME_NS = 125000;
  localparam int UFRAME_CYCLES_DEF = (MICROFRAME_NS * 1000) / CLK_PERIOD_PS;
  localparam int HOST_RESET_NS = 50;
  localparam int HOST_RESET_CYCLES_DEF =
    (HOST_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int N_PORTS_DEF = 1;

  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

/* File: rtl/ehc_cmd_status.sv */
// host command, status and interrupt-enable register group
// assumes one AHB-Lite master on clk_i; port logic on the same clock
`timescale 1ns/1ps

module ehc_cmd_status
  import ehc_pkg::*;
#(
  parameter int N_PORTS = N_PORTS_DEF,
  parameter bit LIGHT_RESET_EN = 1'b1,
  parameter int UFRAME_CYCLES = UFRAME_CYCLES_DEF,
  parameter int RESET_CYCLES = HOST_RESET_CYCLES_DEF
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  input wire logic [N_PORTS-1:0] port_change_i,
  input wire logic [N_PORTS-1:0] companion_handoff_i,
  input wire logic [N_PORTS-1:0] port_suspended_i,
  input wire logic [N_PORTS-1:0] forced_resume_i,
  output logic schedule_run_o,
  output logic core_reset_o,
  output logic port_reset_o,
  output logic [FRAME_IDX_W-1:0] frame_index_o,
  output logic [FRAME_LIST_LENGTH_W-1:0] frame_list_length_o
);

  // ----------------------------------------------------------------
  // sizes and checks
  // ----------------------------------------------------------------
  localparam int UF_W = 16;
  localparam int CNT_W = 8;
  localparam int A_RST_MAX = RESET_CYCLES + 1;
  localparam logic [UF_W-1:0] UF_LAST = UF_W'(UFRAME_CYCLES - 1);
  localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(RESET_CYCLES);

  generate
    if (N_PORTS < 1 || N_PORTS > 15) begin : g_bad_ports
      $error("port count out of range");
    end
    if (UFRAME_CYCLES < 2 || UFRAME_CYCLES > 65536) begin : g_bad_uframe
      $error("microframe cycle count out of range");
    end
    if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_bad_reset
      $error("reset cycle count out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic hrst;
    logic lrst;
    logic [FRAME_LIST_LENGTH_W-1:0] fll;
    logic [CNT_W-1:0] rst_cnt;
    logic [UF_W-1:0] uf_cnt;
    logic [FRAME_IDX_W-1:0] idx;
    logic wrap_flag;
    logic port_flag;
    logic [N_PORTS-1:0] chg_prev;
    logic [N_PORTS-1:0] fres_prev;
    logic dp_wr;
    logic dp_rd;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] rdata;
  } ehc_state_t;

  ehc_state_t s_q;
  ehc_state_t s_d;

  function automatic logic [FRAME_IDX_W-1:0] idx_max(
    input logic [FRAME_LIST_LENGTH_W-1:0] len
  );
    case (len)
      FLL_512: idx_max = IDX_MAX_512;
      FLL_256: idx_max = IDX_MAX_256;
      default: idx_max = IDX_MAX_1024;
    endcase
  endfunction

  function automatic logic [31:0] cmd_word(input ehc_state_t s);
    logic [31:0] w;
    w = HOST_COMMAND_RESET & ~HOST_COMMAND_FIELDS;
    w[RUN_STOP_BIT] = s.run;
    w[HOST_RESET_BIT] = s.hrst;
    w[FRAME_LIST_LENGTH_LSB +: FRAME_LIST_LENGTH_W] = s.fll;
    w[LIGHT_RESET_BIT] = LIGHT_RESET_EN & s.lrst;
    cmd_word = w;
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic addr_ok;
  logic wr_cmd;
  logic wr_sts;
  logic resetting;
  logic uf_end;
  logic wrap_evt;
  logic [N_PORTS-1:0] port_evt;

  assign addr_ok = hsel_i & htrans_i[1] & hready_i & (hsize_i == HSIZE_WORD);
  assign wr_cmd = s_q.dp_wr & (s_q.dp_addr == HOST_COMMAND_OFS);
  assign wr_sts = s_q.dp_wr & (s_q.dp_addr == HOST_STATUS_OFS);
  assign resetting = s_q.rst_cnt != '0;
  assign uf_end = s_q.uf_cnt == UF_LAST;
  // rollover at the length-dependent maximum
  assign wrap_evt = ~resetting & s_q.run & uf_end &
                    (s_q.idx == idx_max(s_q.fll));

  // ----------------------------------------------------------------
  // port event detection
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_PORTS; gi++) begin : g_port
      // ports owned by a companion never raise the flag
      assign port_evt[gi] = ~companion_handoff_i[gi] &
        ((port_change_i[gi] & ~s_q.chg_prev[gi]) |
         (port_suspended_i[gi] & forced_resume_i[gi] &
          ~s_q.fres_prev[gi]));
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // command execution and reset sequencing
    if (resetting) begin
      s_d.rst_cnt = s_q.rst_cnt - CNT_W'(1);
      if (s_q.rst_cnt == CNT_W'(1)) begin
        s_d.hrst = 1'b0;
        s_d.lrst = 1'b0;
      end
    end else if (wr_cmd) begin
      s_d.run = hwdata_i[RUN_STOP_BIT];
      s_d.fll = hwdata_i[FRAME_LIST_LENGTH_LSB +: FRAME_LIST_LENGTH_W];
      if (hwdata_i[HOST_RESET_BIT]) begin
        // full reset returns the command fields to defaults
        s_d.hrst = 1'b1;
        s_d.run = 1'b0;
        s_d.fll = FLL_1024;
        s_d.rst_cnt = RST_LOAD;
      end else if (LIGHT_RESET_EN && hwdata_i[LIGHT_RESET_BIT]) begin
        // core only; port state left untouched
        s_d.lrst = 1'b1;
        s_d.run = 1'b0;
        s_d.rst_cnt = RST_LOAD;
      end
    end

    // schedule timebase, frozen while stopped outside a reset, cleared to zero during a reset
    if (resetting) begin
      s_d.uf_cnt = '0;
      s_d.idx = '0;
    end else if (s_q.run) begin
      if (uf_end) begin
        s_d.uf_cnt = '0;
        s_d.idx = (s_q.idx + FRAME_IDX_W'(1)) & idx_max(s_q.fll);
      end else begin
        s_d.uf_cnt = s_q.uf_cnt + UF_W'(1);
      end
    end

    // sticky flags, a new event beats a clear in the same cycle
    if (s_q.hrst) begin
      s_d.wrap_flag = 1'b0;
      s_d.port_flag = 1'b0;
    end else begin
      s_d.wrap_flag = wrap_evt | (s_q.wrap_flag &
        ~(wr_sts & hwdata_i[FRAME_LIST_WRAP_BIT]));
      s_d.port_flag = (|port_evt) | (s_q.port_flag &
        ~(wr_sts & hwdata_i[PORT_CHANGE_FLAG_BIT]));
    end
    s_d.chg_prev = port_change_i;
    s_d.fres_prev = forced_resume_i & port_suspended_i;

    // address phase capture
    s_d.dp_wr = addr_ok & hwrite_i;
    s_d.dp_rd = addr_ok & ~hwrite_i;
    s_d.dp_addr = haddr_i[ADDR_W-1:0];

    // read data from the updated state so a write just before is seen
    s_d.rdata = '0;
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[ADDR_W-1:0])
        HOST_COMMAND_OFS: s_d.rdata = cmd_word(s_d);
        HOST_STATUS_OFS: begin
          // only the two flags; no transaction outcome here
          s_d.rdata = HOST_STATUS_RESET;
          s_d.rdata[FRAME_LIST_WRAP_BIT] = s_d.wrap_flag;
          s_d.rdata[PORT_CHANGE_FLAG_BIT] = s_d.port_flag;
        end
        HOST_INTR_EN_OFS: s_d.rdata = HOST_INTR_EN_RESET;
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s_q.rdata;
  assign schedule_run_o = s_q.run;
  assign core_reset_o = s_q.hrst | s_q.lrst;
  assign port_reset_o = s_q.hrst;
  assign frame_index_o = s_q.idx;
  assign frame_list_length_o = s_q.fll;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_cmd_run_write: assert property (
    wr_cmd && !resetting && !hwdata_i[HOST_RESET_BIT] &&
    !(LIGHT_RESET_EN && hwdata_i[LIGHT_RESET_BIT])
    |=> schedule_run_o == $past(hwdata_i[RUN_STOP_BIT]) &&
        frame_list_length_o == $past(hwdata_i[3:2]))
    else $error("command write not acted on");

  a_light_keeps_ports: assert property (
    $rose(s_q.lrst) |-> core_reset_o && !port_reset_o ##1
    (!port_reset_o)[*2])
    else $error("light reset touched port state");

  a_light_reads_zero: assert property (
    !LIGHT_RESET_EN && s_q.dp_rd && s_q.dp_addr == HOST_COMMAND_OFS
    |-> !hrdata_o[LIGHT_RESET_BIT])
    else $error("absent light reset bit read as one");

  a_host_reset_start: assert property (
    wr_cmd && !resetting && hwdata_i[HOST_RESET_BIT]
    |=> core_reset_o && port_reset_o && !schedule_run_o ##1
        frame_index_o == '0)
    else $error("host reset not started");

  a_host_reset_done: assert property (
    $rose(port_reset_o) |-> ##[1:A_RST_MAX] !port_reset_o)
    else $error("host reset bit did not clear");

  a_stop_frozen: assert property (
    !schedule_run_o && !core_reset_o |=> $stable(frame_index_o))
    else $error("frame index moved while stopped");

  a_w1c_zero_keeps: assert property (
    wr_sts && !hwdata_i[PORT_CHANGE_FLAG_BIT] && s_q.port_flag &&
    !s_q.hrst |=> s_q.port_flag)
    else $error("status flag cleared by a zero");

  a_w1c_one_clears: assert property (
    wr_sts && hwdata_i[FRAME_LIST_WRAP_BIT] && !wrap_evt
    |=> !s_q.wrap_flag)
    else $error("status flag not cleared by a one");

  a_wrap_sets_flag: assert property (
    wrap_evt && !s_q.hrst |=> s_q.wrap_flag && frame_index_o == '0)
    else $error("rollover did not set wrap flag");

  a_wrap_at_max: assert property (
    $rose(s_q.wrap_flag) |->
    $past(frame_index_o) == idx_max($past(frame_list_length_o)))
    else $error("wrap flag at wrong index");

  a_port_sets_flag: assert property (
    (|port_evt) && !s_q.hrst |=> s_q.port_flag)
    else $error("port event did not set flag");

  a_status_reserved: assert property (
    s_q.dp_rd && s_q.dp_addr == HOST_STATUS_OFS
    |-> (hrdata_o & ~HOST_STATUS_FLAGS) == 32'h00000000)
    else $error("status reserved bits nonzero");

  a_intr_reads_zero: assert property (
    s_q.dp_rd && s_q.dp_addr == HOST_INTR_EN_OFS
    |-> hrdata_o == 32'h00000000)
    else $error("interrupt enable register not empty");

  a_w1c_port_clears: assert property (
    wr_sts && hwdata_i[PORT_CHANGE_FLAG_BIT] && !(|port_evt)
    |=> !s_q.port_flag)
    else $error("port change flag not cleared by a one");

  a_wrap_zero_keeps: assert property (
    wr_sts && !hwdata_i[FRAME_LIST_WRAP_BIT] && s_q.wrap_flag &&
    !s_q.hrst |=> s_q.wrap_flag)
    else $error("wrap flag cleared by a zero");

  // companion-owned ports stay silent
  a_handoff_masked: assert property (
    (&companion_handoff_i) && !s_q.port_flag |=> !s_q.port_flag)
    else $error("companion port raised the change flag");

  a_reset_halts: assert property (
    core_reset_o |-> !schedule_run_o)
    else $error("schedule running during a core reset");

  a_reset_idx_zero: assert property (
    core_reset_o |=> frame_index_o == '0)
    else $error("frame index kept during a core reset");

  a_light_done: assert property (
    $rose(s_q.lrst) |-> ##[1:A_RST_MAX] !s_q.lrst)
    else $error("light reset did not finish");

endmodule

/* File: testbench/tb_ehci_host_command_status_regs.sv */
// bench for the host command and status register group
// assumes ehc_pkg compiled first; drives the bus and port inputs itself
`timescale 1ns/1ps

module tb_ehci_host_command_status_regs
  import ehc_pkg::*;
();
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h0;
  logic [2:0] bsz = HSIZE_WORD;
  logic [0:0] pc = 1'b0, ch = 1'b0, ps = 1'b0, fr = 1'b0;
  wire logic rdy, resp, run, crst, prst;
  wire logic run2, crst2, prst2;
  wire logic [31:0] rd, rd2;
  wire logic [12:0] idx, idx2;
  wire logic [1:0] fll, fll2;
  logic rdy_s;
  logic [31:0] rd_s, rd2_s;
  int n_checks = 0;
  int n_mismatch = 0;
  int seed = 24042;

  ehc_cmd_status #(.N_PORTS(1), .LIGHT_RESET_EN(1'b1),
    .UFRAME_CYCLES(8), .RESET_CYCLES(6)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(rdy),
    .hreadyout_o(rdy), .hresp_o(resp), .hrdata_o(rd),
    .port_change_i(pc), .companion_handoff_i(ch),
    .port_suspended_i(ps), .forced_resume_i(fr),
    .schedule_run_o(run), .core_reset_o(crst), .port_reset_o(prst),
    .frame_index_o(idx), .frame_list_length_o(fll));

  // same bus, built without light reset support
  ehc_cmd_status #(.N_PORTS(1), .LIGHT_RESET_EN(1'b0),
    .UFRAME_CYCLES(8), .RESET_CYCLES(6)) dut_nolr (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(rdy),
    .hreadyout_o(), .hresp_o(), .hrdata_o(rd2),
    .port_change_i(pc), .companion_handoff_i(ch),
    .port_suspended_i(ps), .forced_resume_i(fr),
    .schedule_run_o(run2), .core_reset_o(crst2), .port_reset_o(prst2),
    .frame_index_o(idx2), .frame_list_length_o(fll2));

  always #2.5 clk_i = ~clk_i;

  // bus answers as sampled at the rising edge
  always @(posedge clk_i) begin
    rdy_s <= rdy;
    rd_s <= rd;
    rd2_s <= rd2;
  end

  // ----------------------------------------------------------------
  // tasks and expectations
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tmo(input logic ok, input string m);
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t timeout %s", $time, m);
      close_out();
    end
  endtask

  task tick;
    @(posedge clk_i);
    #1;
  endtask

  task automatic hwait;
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (rdy_s !== 1'b1 && n < 20);
    tmo(rdy_s, "bus");
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    hsize_i <= bsz;
    hwait();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    hwait();
    q = rd_s;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask

  function automatic logic [31:0] ecmd(logic r, logic [1:0] l,
                                       logic h, logic lr);
    ecmd = HOST_COMMAND_RESET | {24'h0, lr, 3'h0, l, h, r};
  endfunction

  function automatic logic [12:0] imax(logic [1:0] l);
    case (l)
      FLL_512: imax = IDX_MAX_512;
      FLL_256: imax = IDX_MAX_256;
      default: imax = IDX_MAX_1024;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [31:0] d;
    logic [1:0] l;
    logic [12:0] i0;
    repeat (5) tick();
    reset_n_i <= 1'b1;
    chk(run, 0, "run rst");
    chk({crst, prst, resp, rdy}, 4'h1, "out rst");
    rdc(HOST_COMMAND_OFS, ecmd(0, 0, 0, 0), "cmd rst");
    rdc(HOST_STATUS_OFS, 32'h0, "sts rst");
    rdc(8'h30, 32'h0, "unmapped");
    repeat (4) begin
      d = $random(seed);
      wr(HOST_INTR_EN_OFS, d);
      rdc(HOST_INTR_EN_OFS, 32'h0, "intr");
    end
    for (int k = 0; k < 5; k++) begin
      l = (k < 3) ? k[1:0] : 2'($unsigned($random(seed)) % 3);
      wr(HOST_COMMAND_OFS, ecmd(1, l, 0, 0));
      chk(run, 1, "run");
      chk(fll, l, "len");
      rdc(HOST_COMMAND_OFS, ecmd(1, l, 0, 0), "cmd rd");
      wr(HOST_COMMAND_OFS, ecmd(0, l, 0, 0));
      chk(run, 0, "stop");
    end
    // non-word transfers are dropped and read zero
    bsz = 3'h1;
    wr(HOST_COMMAND_OFS, ecmd(1, 2'h1, 0, 0));
    bsz = 3'h0;
    rdc(HOST_COMMAND_OFS, 32'h0, "byte rd");
    bsz = HSIZE_WORD;
    chk({run, fll}, {1'b0, l}, "byte wr");
    pc <= 1'b1;
    repeat (2) tick();
    rdc(HOST_STATUS_OFS, 32'h4, "pcd set");
    pc <= 1'b0;
    wr(HOST_STATUS_OFS, 32'h0);
    rdc(HOST_STATUS_OFS, 32'h4, "w0 keeps");
    wr(HOST_STATUS_OFS, 32'h4);
    rdc(HOST_STATUS_OFS, 32'h0, "w1 clears");
    ch <= 1'b1;
    pc <= 1'b1;
    repeat (2) tick();
    rdc(HOST_STATUS_OFS, 32'h0, "handoff");
    pc <= 1'b0;
    ch <= 1'b0;
    ps <= 1'b1;
    fr <= 1'b1;
    repeat (2) tick();
    rdc(HOST_STATUS_OFS, 32'h4, "resume");
    fr <= 1'b0;
    ps <= 1'b0;
    wr(HOST_STATUS_OFS, 32'h4);
    l = FLL_256;
    wr(HOST_COMMAND_OFS, ecmd(1, l, 0, 0));
    n = 0;
    while (idx !== imax(l) && n < 20000) begin
      tick();
      n++;
    end
    tmo(idx === imax(l), "index max");
    n = 0;
    while (idx === imax(l) && n < 20) begin
      tick();
      n++;
    end
    chk(idx, 0, "wrap");
    rdc(HOST_STATUS_OFS, 32'h8, "wrap flag");
    wr(HOST_STATUS_OFS, 32'h4);
    rdc(HOST_STATUS_OFS, 32'h8, "w0 wrap keeps");
    wr(HOST_COMMAND_OFS, ecmd(0, l, 0, 0));
    i0 = idx;
    repeat (20) tick();
    chk(idx, i0, "frozen");
    wr(HOST_STATUS_OFS, 32'h8);
    rdc(HOST_STATUS_OFS, 32'h0, "wrap clr");
    wr(HOST_COMMAND_OFS, ecmd(0, 0, 0, 1));
    chk({crst, prst}, 2'h2, "light");
    chk({crst2, prst2}, 2'h0, "no light rst");
    // a command during a running reset is ignored
    wr(HOST_COMMAND_OFS, ecmd(1, 2'h1, 0, 0));
    chk({run, fll}, 3'h0, "busy wr");
    chk({run2, fll2}, 3'h5, "nolr wr");
    bus(1'b0, HOST_COMMAND_OFS, 32'h0, d);
    chk(d, ecmd(0, 0, 0, 1), "light rd");
    chk(rd2_s, ecmd(1, 1, 0, 0), "no light");
    n = 0;
    while (crst !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    tmo(crst === 1'b0, "light end");
    pc <= 1'b1;
    repeat (2) tick();
    pc <= 1'b0;
    wr(HOST_COMMAND_OFS, ecmd(1, 2'h2, 0, 0));
    wr(HOST_COMMAND_OFS, ecmd(1, 2'h2, 1, 0));
    chk({crst, prst, run}, 3'h6, "hreset");
    chk({crst2, prst2, run2}, 3'h6, "nolr hreset");
    rdc(HOST_COMMAND_OFS, ecmd(0, 0, 1, 0), "hreset rd");
    n = 0;
    while (crst !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    tmo(crst === 1'b0, "hreset end");
    rdc(HOST_COMMAND_OFS, ecmd(0, 0, 0, 0), "hreset done");
    rdc(HOST_STATUS_OFS, 32'h0, "hreset flags");
    chk({idx, idx2}, 26'h0, "hreset idx");
    chk({fll2, run2}, 3'h0, "nolr done");
    close_out();
  end
endmodule
